/* File: transport_pkg.sv */
// Constants and types shared by the scan transport logic.
// Assumes a five-bit instruction register and a 41-bit access chain.
package transport_pkg;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam int         IR_W   = 5;      // Instruction width
  localparam logic [4:0] IR_ID  = 5'h01;  // Identification
  localparam logic [4:0] IR_CS  = 5'h10;  // Control/status
  localparam logic [4:0] IR_ACC = 5'h11;  // Module access
  localparam logic [4:0] IR_BYP = 5'h1f;  // Bypass
  localparam logic [4:0] IR_CAP = 5'h01;  // Instruction capture

  // ----------------------------------------------------------------
  // Access chain layout
  // ----------------------------------------------------------------
  localparam int ACC_W        = 41;  // Access chain length
  localparam int ADDR_W       = 7;   // Address field width
  localparam int DATA_W       = 32;  // Data field width
  localparam int ACC_ADDR_LSB = 34;  // Address field base
  localparam int ACC_DATA_LSB = 2;   // Data field base

  // Top bit of each chain, where scan data enters
  localparam logic [5:0] ACC_MSB  = 6'h28;  // Bit 40
  localparam logic [5:0] WORD_MSB = 6'h1f;  // Bit 31
  localparam logic [5:0] BYP_MSB  = 6'h00;  // Bit 0

  // Operation codes
  localparam logic [1:0] OP_NOP = 2'h0;  // Nothing
  localparam logic [1:0] OP_RD  = 2'h1;  // Read
  localparam logic [1:0] OP_WR  = 2'h2;  // Write
  localparam logic [1:0] OP_OK  = 2'h0;  // Status: success

  // ----------------------------------------------------------------
  // Control/status fields
  // ----------------------------------------------------------------
  localparam logic [13:0] CS_RSVD_HI = 14'h0000;  // Bits 31:18
  localparam logic        CS_HARD    = 1'b0;      // Bit 17
  localparam logic        CS_ERRCLR  = 1'b0;      // Bit 16
  localparam logic        CS_RSVD15  = 1'b0;      // Bit 15
  localparam logic [2:0]  CS_IDLE    = 3'h0;      // Bits 14:12
  localparam logic [1:0]  CS_STAT    = 2'h0;      // Bits 11:10
  localparam logic [5:0]  CS_ABITS   = 6'h07;     // Bits 9:4
  localparam logic [3:0]  CS_VER     = 4'h1;      // Bits 3:0

  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;   // Address
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0;   // Data

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TEST_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR,
    PAUSE_DR, EXIT2_DR, UPD_DR, SEL_IR, CAP_IR, SHIFT_IR,
    EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } tap_state_t;

  typedef enum logic {C_IDLE, C_WAIT} core_state_t;

endpackage : transport_pkg

/* File: bit_sync.sv */
// Two-flop level synchroniser, any width.
// Assumes each bit is a level that holds for several clocks.
module bit_sync
  import transport_pkg::*;
#(
  parameter int W = 1  // Bits carried
) (
  input  wire logic         clk,  // Destination clock
  input  wire logic         rst,  // Sync reset, high
  input  wire logic [W-1:0] d,    // Foreign level
  output logic      [W-1:0] q     // Settled level
);

  // First stage, read only by q
  logic [W-1:0] meta_reg;

  // Two stages, no logic between
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : bit_sync

/* File: jtag_debug_transport_regs.sv */
// Scan transport registers: test port, chains, core handshake.
// Assumes TMS, TDI, TRST change on TCK falling edges.
// How it works
// - Five-bit instruction selects the data chain
// - Codes 01, 10, 11 select three registers
// - Port reset selects identification register
// - Version, part number come from identity input
// - Maker bits from input, bit zero one
// - Words cross clocks through a toggle handshake
// - Hard-reset bit reads zero, writes ignored
// - Error-clear bit reads zero, writes ignored
// - Idle hint reads zero
// - Access status reads zero, no error
// - Address width field reads seven
// - Version field reads one
// - Update starts access, capture returns result
// - Access chain: address, data, operation
// - Operation codes nop, read, write; three unused
// - Other codes select one-bit bypass
module jtag_debug_transport_regs
  import transport_pkg::*;
(
  input  wire logic              REF_CLK,       // Core clock
  input  wire logic              RST,           // Core reset
  input  wire logic              TCK,           // Test clock
  input  wire logic              TRST,          // Test reset
  input  wire logic              TMS,           // Mode select
  input  wire logic              TDI,           // Scan in
  output logic                   TDO,           // Scan out
  output logic                   TDO_EN,        // Scan out on
  input  wire logic [31:0]       ID_VECTOR,     // Identity
  output logic                   DM_REQ,        // Request pulse
  output logic                   DM_WRITE,      // 1 write
  output logic [ADDR_W-1:0]      DM_ADDR,       // Address
  output logic [DATA_W-1:0]      DM_WDATA,      // Write data
  input  wire logic              DM_RSP_VALID,  // Answer
  input  wire logic [DATA_W-1:0] DM_RDATA       // Read data
);

  // ----------------------------------------------------------------
  // Test clock domain state
  // ----------------------------------------------------------------
  tap_state_t        tap_reg;        // Port state
  tap_state_t        tap_next;       // Next port state
  logic [IR_W-1:0]   ir_reg;         // Active instruction
  logic [IR_W-1:0]   ir_shift_reg;   // Instruction chain
  logic [ACC_W-1:0]  dr_shift_reg;   // Data chain
  logic [ACC_W-1:0]  dr_next;        // Chain after a shift
  logic [ADDR_W-1:0] acc_addr_reg;   // Last address sent
  logic [DATA_W-1:0] rsp_data_reg;   // Last result
  logic              req_tgl_reg;    // Flips per request
  logic              ack_seen_reg;   // Last answer toggle
  logic [ADDR_W-1:0] hold_addr_reg;  // Address to core
  logic [DATA_W-1:0] hold_data_reg;  // Data to core
  logic              hold_wr_reg;    // Direction to core
  logic              tdo_reg;        // Scan out flop
  logic              tdo_en_reg;     // Drive flop
  logic [31:0]       id_sync;        // Identity, settled
  logic              ack_sync;       // Answer toggle, settled

  // ----------------------------------------------------------------
  // Core clock domain state
  // ----------------------------------------------------------------
  core_state_t       core_state_reg;  // Request tracker
  logic              req_sync;        // Request toggle
  logic              req_seen_reg;    // Last request toggle
  logic              ack_tgl_reg;     // Flips per answer
  logic [DATA_W-1:0] core_rdata_reg;  // Read result
  logic              dm_req_reg;      // Request pulse flop
  logic              dm_wr_reg;       // Direction flop
  logic [ADDR_W-1:0] dm_addr_reg;     // Address flop
  logic [DATA_W-1:0] dm_wdata_reg;    // Write data flop

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  wire sel_id;   // Identification chosen
  wire sel_cs;   // Control/status chosen
  wire sel_acc;  // Access chain chosen
  wire sel_byp;  // Bypass chosen

  assign sel_id  = (ir_reg == IR_ID);
  assign sel_cs  = (ir_reg == IR_CS);
  assign sel_acc = (ir_reg == IR_ACC);
  // Any unassigned code, IR_BYP among them, falls here
  assign sel_byp = !(sel_id || sel_cs || sel_acc);

  // Entry bit of the selected chain
  wire [5:0] dr_msb;
  assign dr_msb = sel_acc ? ACC_MSB :
                  sel_byp ? BYP_MSB : WORD_MSB;

  // ----------------------------------------------------------------
  // Capture values
  // ----------------------------------------------------------------
  wire [31:0]      id_word;   // Identification word
  wire [31:0]      cs_word;   // Control/status word
  wire [ACC_W-1:0] acc_word;  // Access chain word
  wire [ACC_W-1:0] cap_word;  // Word for Capture-DR

  // Bit 0 is forced high whatever the strap says
  assign id_word = {id_sync[31:1], 1'b1};

  // Constant word; nothing scanned in ever reaches it
  assign cs_word = {CS_RSVD_HI,
                    CS_HARD,
                    CS_ERRCLR,
                    CS_RSVD15,
                    CS_IDLE,
                    CS_STAT,
                    CS_ABITS,
                    CS_VER};

  // Status always success: accesses cannot fail
  assign acc_word = {acc_addr_reg, rsp_data_reg, OP_OK};

  assign cap_word = sel_acc ? acc_word :
                    sel_byp ? '0 :
                    {9'h000, sel_id ? id_word : cs_word};

  // ----------------------------------------------------------------
  // Access start decode
  // ----------------------------------------------------------------
  wire [1:0] acc_op;   // Scanned operation field
  wire       pending;  // Request not yet answered
  wire       op_go;    // Start an access now
  wire       ack_edge; // Answer arrived

  assign acc_op   = dr_shift_reg[1:0];
  assign pending  = req_tgl_reg ^ ack_seen_reg;
  assign ack_edge = ack_sync ^ ack_seen_reg;
  // Code 3 and nop start nothing; a busy request wins
  assign op_go = (tap_reg == UPD_DR) && sel_acc && !pending &&
                 ((acc_op == OP_RD) || (acc_op == OP_WR));

  // ----------------------------------------------------------------
  // Port state machine
  // ----------------------------------------------------------------
  // Standard sixteen-state walk on TMS
  always_comb begin
    tap_next = tap_reg;
    unique case (tap_reg)
      TEST_RESET: tap_next = TMS ? TEST_RESET : RUN_IDLE;
      RUN_IDLE:   tap_next = TMS ? SEL_DR : RUN_IDLE;
      SEL_DR:     tap_next = TMS ? SEL_IR : CAP_DR;
      CAP_DR:     tap_next = TMS ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR:   tap_next = TMS ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR:   tap_next = TMS ? UPD_DR : PAUSE_DR;
      PAUSE_DR:   tap_next = TMS ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR:   tap_next = TMS ? UPD_DR : SHIFT_DR;
      UPD_DR:     tap_next = TMS ? SEL_DR : RUN_IDLE;
      SEL_IR:     tap_next = TMS ? TEST_RESET : CAP_IR;
      CAP_IR:     tap_next = TMS ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR:   tap_next = TMS ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR:   tap_next = TMS ? UPD_IR : PAUSE_IR;
      PAUSE_IR:   tap_next = TMS ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR:   tap_next = TMS ? UPD_IR : SHIFT_IR;
      UPD_IR:     tap_next = TMS ? SEL_DR : RUN_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge TCK) begin
    if (TRST) begin
      tap_reg <= TEST_RESET;
    end else begin
      tap_reg <= tap_next;
    end
  end

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  // Reset state always leaves identification selected
  always_ff @(posedge TCK) begin
    if (TRST || (tap_reg == TEST_RESET)) begin
      ir_reg <= IR_ID;
    end else if (tap_reg == UPD_IR) begin
      ir_reg <= ir_shift_reg;
    end
  end

  // Instruction chain, low bit out first
  always_ff @(posedge TCK) begin
    if (TRST) begin
      ir_shift_reg <= IR_CAP;
    end else if (tap_reg == CAP_IR) begin
      ir_shift_reg <= IR_CAP;
    end else if (tap_reg == SHIFT_IR) begin
      ir_shift_reg <= {TDI, ir_shift_reg[IR_W-1:1]};
    end
  end

  // ----------------------------------------------------------------
  // Data chain
  // ----------------------------------------------------------------
  // Shift right; TDI enters at the selected chain's top
  always_comb begin
    dr_next         = dr_shift_reg >> 1;
    dr_next[dr_msb] = TDI;
  end

  // One chain serves all registers
  always_ff @(posedge TCK) begin
    if (TRST) begin
      dr_shift_reg <= '0;
    end else if (tap_reg == CAP_DR) begin
      dr_shift_reg <= cap_word;
    end else if (tap_reg == SHIFT_DR) begin
      dr_shift_reg <= dr_next;
    end
  end

  // ----------------------------------------------------------------
  // Access request and result, test side
  // ----------------------------------------------------------------
  // Held words stay still until the core answers
  always_ff @(posedge TCK) begin
    if (TRST) begin
      acc_addr_reg  <= ADDR_RST;
      hold_addr_reg <= ADDR_RST;
      hold_data_reg <= DATA_RST;
      hold_wr_reg   <= 1'b0;
      req_tgl_reg   <= 1'b0;
    end else if (op_go) begin
      acc_addr_reg  <= dr_shift_reg[ACC_W-1:ACC_ADDR_LSB];
      hold_addr_reg <= dr_shift_reg[ACC_W-1:ACC_ADDR_LSB];
      hold_data_reg <= dr_shift_reg[ACC_ADDR_LSB-1:ACC_DATA_LSB];
      hold_wr_reg   <= (acc_op == OP_WR);
      req_tgl_reg   <= ~req_tgl_reg;
    end
  end

  // Result taken once the answer toggle settles
  always_ff @(posedge TCK) begin
    if (TRST) begin
      ack_seen_reg <= 1'b0;
      rsp_data_reg <= DATA_RST;
    end else if (ack_edge) begin
      ack_seen_reg <= ack_sync;
      rsp_data_reg <= core_rdata_reg;
    end
  end

  // ----------------------------------------------------------------
  // Scan output
  // ----------------------------------------------------------------
  // Falling edge so the probe samples a settled bit
  always_ff @(negedge TCK) begin
    if (TRST) begin
      tdo_reg    <= 1'b0;
      tdo_en_reg <= 1'b0;
    end else begin
      tdo_reg    <= (tap_reg == SHIFT_IR) ? ir_shift_reg[0]
                                          : dr_shift_reg[0];
      tdo_en_reg <= (tap_reg == SHIFT_IR) || (tap_reg == SHIFT_DR);
    end
  end

  assign TDO    = tdo_reg;
  assign TDO_EN = tdo_en_reg;

  // ----------------------------------------------------------------
  // Clock crossings
  // ----------------------------------------------------------------
  // Static strap, settled on the test clock
  bit_sync #(.W(32)) u_id_sync (
    .clk (TCK),
    .rst (TRST),
    .d   (ID_VECTOR),
    .q   (id_sync)
  );

  // Answer toggle into the test domain
  bit_sync #(.W(1)) u_ack_sync (
    .clk (TCK),
    .rst (TRST),
    .d   (ack_tgl_reg),
    .q   (ack_sync)
  );

  // Request toggle into the core domain
  bit_sync #(.W(1)) u_req_sync (
    .clk (REF_CLK),
    .rst (RST),
    .d   (req_tgl_reg),
    .q   (req_sync)
  );

  // ----------------------------------------------------------------
  // Core side request tracker
  // ----------------------------------------------------------------
  wire req_edge;  // New request seen
  wire take_req;  // Issue it now
  wire take_rsp;  // Answer arrived

  assign req_edge = req_sync ^ req_seen_reg;
  assign take_req = (core_state_reg == C_IDLE) && req_edge;
  assign take_rsp = (core_state_reg == C_WAIT) && DM_RSP_VALID;

  // One request outstanding at a time
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      core_state_reg <= C_IDLE;
    end else if (take_req) begin
      core_state_reg <= C_WAIT;
    end else if (take_rsp) begin
      core_state_reg <= C_IDLE;
    end
  end

  // Held words are stable here: the toggle came after them
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      req_seen_reg <= 1'b0;
      dm_req_reg   <= 1'b0;
      dm_wr_reg    <= 1'b0;
      dm_addr_reg  <= ADDR_RST;
      dm_wdata_reg <= DATA_RST;
    end else begin
      dm_req_reg <= take_req;
      if (take_req) begin
        req_seen_reg <= req_sync;
        dm_wr_reg    <= hold_wr_reg;
        dm_addr_reg  <= hold_addr_reg;
        dm_wdata_reg <= hold_data_reg;
      end
    end
  end

  // Writes keep the previous read result
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      core_rdata_reg <= DATA_RST;
      ack_tgl_reg    <= 1'b0;
    end else if (take_rsp) begin
      if (!dm_wr_reg) begin
        core_rdata_reg <= DM_RDATA;
      end
      ack_tgl_reg <= ~ack_tgl_reg;
    end
  end

  assign DM_REQ   = dm_req_reg;
  assign DM_WRITE = dm_wr_reg;
  assign DM_ADDR  = dm_addr_reg;
  assign DM_WDATA = dm_wdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Five high TMS bits always land in reset
  AST_TAP_RESET: assert property (
    @(posedge TCK) disable iff (TRST)
    TMS [*5] |=> (tap_reg == TEST_RESET))
    else $error("port not in reset after five TMS highs");

  AST_IR_RESET: assert property (
    @(posedge TCK) disable iff (TRST)
    (tap_reg == TEST_RESET) |=> (ir_reg == IR_ID))
    else $error("reset did not select identification");

  AST_DECODE: assert property (
    @(posedge TCK) disable iff (TRST)
    (ir_reg == IR_ACC) |-> (dr_msb == ACC_MSB))
    else $error("access code did not pick 41-bit chain");

  AST_ID_HIGH: assert property (
    @(posedge TCK) disable iff (TRST)
    (tap_reg == CAP_DR && sel_id) |=>
      (dr_shift_reg[31:12] == $past(id_sync[31:12])))
    else $error("identity version or part wrong");

  AST_ID_LOW: assert property (
    @(posedge TCK) disable iff (TRST)
    (tap_reg == CAP_DR && sel_id) |=>
      (dr_shift_reg[11:0] == {$past(id_sync[11:1]), 1'b1}))
    else $error("identity maker bits or bit 0 wrong");

  AST_CS_ZERO: assert property (
    @(posedge TCK) disable iff (TRST)
    (tap_reg == CAP_DR && sel_cs) |=> (dr_shift_reg[31:10] == '0))
    else $error("control/status upper bits not zero");

  AST_CS_ABITS: assert property (
    @(posedge TCK) disable iff (TRST)
    (tap_reg == CAP_DR && sel_cs) |=> (dr_shift_reg[9:4] == 6'h07))
    else $error("address width field not seven");

  AST_CS_VER: assert property (
    @(posedge TCK) disable iff (TRST)
    (tap_reg == CAP_DR && sel_cs) |=> (dr_shift_reg[3:0] == 4'h1))
    else $error("version field not one");

  AST_ACC_CAP: assert property (
    @(posedge TCK) disable iff (TRST)
    (tap_reg == CAP_DR && sel_acc) |=>
      (dr_shift_reg[40:2] == {$past(acc_addr_reg), $past(rsp_data_reg)}))
    else $error("access chain capture layout wrong");

  AST_OP_OK: assert property (
    @(posedge TCK) disable iff (TRST)
    (tap_reg == CAP_DR && sel_acc) |=> (dr_shift_reg[1:0] == 2'h0))
    else $error("operation status not success");

  AST_BYP_SHIFT: assert property (
    @(posedge TCK) disable iff (TRST)
    (tap_reg == SHIFT_DR && sel_byp) |=> (dr_shift_reg[0] == $past(TDI)))
    else $error("bypass is not a one-bit delay");

  AST_UPD_GO: assert property (
    @(posedge TCK) disable iff (TRST)
    op_go |=> (req_tgl_reg != $past(req_tgl_reg)))
    else $error("update did not start the access");

  AST_CS_RO: assert property (
    @(posedge TCK) disable iff (TRST)
    (tap_reg == UPD_DR && sel_cs) |=>
      $stable(req_tgl_reg) && $stable(ir_reg))
    else $error("control/status update had an effect");

  AST_DM_REQ: assert property (
    @(posedge REF_CLK) disable iff (RST)
    take_req |=> DM_REQ ##1 !DM_REQ)
    else $error("request pulse not one core cycle");

endmodule : jtag_debug_transport_regs

/* File: jtag_probe.sv */
// Debugger probe model: owns the test clock and the scan pins.
// Assumes the port samples mode and scan-in on rising test-clock edges.
module jtag_probe (
  output logic      tck,   // Test clock, runs only inside tasks
  output logic      trst,  // Test reset, high
  output logic      tms,   // Mode select
  output logic      tdi,   // Scan in
  input  wire logic tdo    // Scan out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Port held in reset until the bench asks for a frame
  initial begin
    tck = 1'b0;
    trst = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One 32 ns period; pins move while the clock is low
  task automatic cyc(input logic ms, input logic di, output logic o);
    tms = ms;
    tdi = di;
    #16;
    o = tdo;
    tck = 1'b1;
    #16;
    tck = 1'b0;
  endtask : cyc

  // Step outside shifting; scan-in flips so stale data never looks good
  task automatic nx(input logic ms);
    logic o;
    cyc(ms, ~tdi, o);
  endtask : nx

  task automatic idle(input int n);
    repeat (n) nx(1'b0);
  endtask : idle

  // Reset by pin, then park in Run-Test/Idle
  task automatic port_reset();
    trst = 1'b1;
    repeat (3) nx(1'b1);
    trst = 1'b0;
    idle(3);
  endtask : port_reset

  // Five mode-high steps reach reset without the pin
  task automatic tms_reset();
    repeat (5) nx(1'b1);
    idle(1);
  endtask : tms_reset

  // Shift either the instruction or the data chain, LSB first
  task automatic scan(input logic ir, input int n, input logic [40:0] din,
                      output logic [40:0] dout);
    dout = '0;
    nx(1'b1);
    if (ir)
      nx(1'b1);
    nx(1'b0);
    nx(1'b0);
    for (int i = 0; i < n; i++)
      cyc(i == n - 1, din[i], dout[i]);
    nx(1'b1);
    nx(1'b0);
  endtask : scan
endmodule : jtag_probe

/* File: tb_jtag_debug_transport_regs.sv */
// Self-checking bench for the scan transport registers.
// Assumes the probe model and a behavioural debug module on the core side.
module tb_jtag_debug_transport_regs
  import transport_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [31:0] ID_VAL = 32'h1234_5676;  // Arbitrary identity, bit 0 clear
  logic REF_CLK, RST, TCK, TRST, TMS, TDI, TDO, TDO_EN, DM_REQ, DM_WRITE, DM_RSP_VALID;
  logic [ADDR_W-1:0] DM_ADDR;                 // Request address
  logic [DATA_W-1:0] DM_WDATA, DM_RDATA;      // Core data
  logic [DATA_W-1:0] mem [128];               // Module register file
  logic [2:0]        rsp_cnt;                 // Answer delay
  logic [40:0]       got;                     // Last scan-out
  int                n_req, mismatches, total_checks, en_cnt;  // en_cnt: bits driven out

  jtag_debug_transport_regs dut_u (.REF_CLK, .RST, .TCK, .TRST, .TMS, .TDI, .TDO,
    .TDO_EN, .ID_VECTOR(ID_VAL), .DM_REQ, .DM_WRITE, .DM_ADDR, .DM_WDATA,
    .DM_RSP_VALID, .DM_RDATA);
  jtag_probe prb_u (.tck(TCK), .trst(TRST), .tms(TMS), .tdi(TDI), .tdo(TDO));

  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end

  // Debug module: one answer three cycles after each request
  always @(posedge REF_CLK) begin
    DM_RSP_VALID <= 1'b0;
    DM_RDATA <= ~DM_RDATA;  // Not valid: keep it moving
    if (DM_REQ) begin
      n_req <= n_req + 1;
      rsp_cnt <= 3'h3;
      if (DM_WRITE)
        mem[DM_ADDR] <= DM_WDATA;
    end else if (rsp_cnt != 3'h0) begin
      rsp_cnt <= rsp_cnt - 3'h1;
      if (rsp_cnt == 3'h1) begin
        DM_RSP_VALID <= 1'b1;
        DM_RDATA <= mem[DM_ADDR];
      end
    end
  end

  // Rising edges that see the scan-out driven; one per shifted bit
  always @(posedge TCK) begin
    if (TDO_EN)
      en_cnt <= en_cnt + 1;
  end

  task automatic chk(input string nm, input logic [40:0] seen, input logic [40:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // Gap so the answer crosses back before the next capture
  task automatic settle();
    repeat (15) @(posedge REF_CLK);
    prb_u.idle(8);
  endtask : settle

  // Identity after pin reset and after a mode-only reset
  task automatic t_id();
    prb_u.scan(1'b0, 32, 41'h0, got);
    chk("identification_code", got, {ID_VAL[31:1], 1'b1});
    prb_u.scan(1'b1, IR_W, 41'(IR_CS), got);
    chk("ir_capture", got, 41'h01);
    prb_u.tms_reset();
    prb_u.scan(1'b0, 32, 41'h0, got);
    chk("identification_code_tms", got, {ID_VAL[31:1], 1'b1});
    $display("t_id done");
  endtask : t_id

  // Status word is constant; scanned ones change nothing
  task automatic t_cs();
    prb_u.scan(1'b1, IR_W, 41'(IR_CS), got);
    repeat (2) begin
      prb_u.scan(1'b0, 32, '1, got);
      chk("status", got, 41'h71);
    end
    $display("t_cs done");
  endtask : t_cs

  // Listed and unlisted codes give a one-bit delay
  task automatic t_byp();
    logic [4:0] codes [4] = '{IR_BYP, 5'h00, 5'h02, 5'h12};
    int         e0;
    foreach (codes[i]) begin
      prb_u.scan(1'b1, IR_W, 41'(codes[i]), got);
      e0 = en_cnt;
      prb_u.scan(1'b0, 3, 41'h5, got);
      chk("bypass", got, 41'h2);
      chk("tdo_en", en_cnt - e0, 41'h3);
    end
    $display("t_byp done");
  endtask : t_byp

  // Write, read back, then op 3 and nop start nothing
  task automatic t_acc();
    prb_u.scan(1'b1, IR_W, 41'(IR_ACC), got);
    prb_u.scan(1'b0, ACC_W, {7'h05, 32'hcafe_0001, OP_WR}, got);
    settle();
    chk("req_wr", {DM_WRITE, DM_ADDR, DM_WDATA}, {1'b1, 7'h05, 32'hcafe_0001});
    prb_u.scan(1'b0, ACC_W, {7'h05, 32'h0, OP_RD}, got);
    chk("cap_wr", got, {7'h05, 32'h0, OP_OK});
    settle();
    chk("req_rd", {n_req[3:0], DM_WRITE, DM_ADDR}, {4'h2, 1'b0, 7'h05});
    prb_u.scan(1'b0, ACC_W, {7'h09, 32'h0, 2'h3}, got);
    chk("cap_rd", got, {7'h05, 32'hcafe_0001, OP_OK});
    settle();
    prb_u.scan(1'b0, ACC_W, {7'h0a, 32'h0, OP_NOP}, got);
    chk("cap_op3", got, {7'h05, 32'hcafe_0001, OP_OK});
    settle();
    chk("req_none", n_req, 41'h2);
    $display("t_acc done");
  endtask : t_acc

  // Watchdog well beyond the expected run
  initial begin
    #500000;
    mismatches++;
    test_done();
  end

  // Both resets together, then the tests
  initial begin
    RST = 1'b1;
    DM_RSP_VALID = 1'b0;
    DM_RDATA = '0;
    rsp_cnt = 3'h0;
    n_req = 0;
    mismatches = 0;
    total_checks = 0;
    en_cnt = 0;
    fork
      prb_u.port_reset();
      repeat (10) @(posedge REF_CLK);
    join
    RST <= 1'b0;
    t_id();
    t_cs();
    t_byp();
    t_acc();
    test_done();
  end
endmodule : tb_jtag_debug_transport_regs
